// ---- rtl/arc_pkg.sv ----
// constants for the converter result, compare and configuration registers
// assumes an 8-bit register port clocked by the bus clock
package arc_pkg;
	localparam int ADDR_W = 4;
	localparam logic [3:0] OFF_RES_HI = 4'h0;
	localparam logic [3:0] OFF_RES_LO = 4'h1;
	localparam logic [3:0] OFF_CMP_HI = 4'h2;
	localparam logic [3:0] OFF_CMP_LO = 4'h3;
	localparam logic [3:0] OFF_CFG = 4'h4;
	localparam logic [3:0] OFF_PIN_LO = 4'h5;
	localparam logic [3:0] OFF_PIN_MID = 4'h6;
	localparam logic [3:0] OFF_PIN_HI = 4'h7;
	localparam logic [3:0] OFF_CTRL = 4'h8;
	localparam logic [3:0] OFF_STAT = 4'h9;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam int CFG_LPC = 7;
	localparam int CFG_DIV_HI = 6;
	localparam int CFG_DIV_LO = 5;
	localparam int CFG_LSMP = 4;
	localparam int CFG_MODE_HI = 3;
	localparam int CFG_MODE_LO = 2;
	localparam int CFG_CLK_HI = 1;
	localparam int CFG_CLK_LO = 0;
	localparam logic [1:0] MODE_8BIT = 2'h0;
	localparam logic [1:0] MODE_10BIT = 2'h2;
	localparam int CTRL_CMP_EN = 0;
	localparam int CTRL_CMP_GT = 1;
	localparam int STAT_CONVERSION_COMPLETE_FLAG = 0;
	localparam int STAT_BLOCK = 1;
	localparam int STAT_VALID = 2;
	localparam logic [2:0] DIV_MAX = 3'h7;
endpackage : arc_pkg

// ---- rtl/arc_pin_group.sv ----
// one group of eight channel pins handed to analog use
// assumes port-side pad signals are synchronous to the bus clock
`timescale 1ns/1ps
`default_nettype none
module arc_pin_group #(
	parameter int W = 8
) (
	input wire logic [W-1:0] disable_i,
	input wire logic [W-1:0] port_out_i,
	input wire logic [W-1:0] port_oe_i,
	input wire logic [W-1:0] pad_in_i,
	output logic [W-1:0] pad_out_o,
	output logic [W-1:0] pad_oe_o,
	output logic [W-1:0] port_in_o
);
	// disabled pins float, input reads zero
	assign pad_out_o = port_out_i & ~disable_i;
	assign pad_oe_o = port_oe_i & ~disable_i;
	assign port_in_o = pad_in_i & ~disable_i;
endmodule : arc_pin_group
`default_nettype wire

// ---- rtl/arc_regs.sv ----
// result, compare, configuration and pin-disable registers of the converter
// assumes conversion core supplies one-cycle completion pulses with a 10-bit result
//
// Function
// - high result shows bits 9:8, zero in 8-bit
// - result loads on completion unless compare fails
// - high read blocks transfers until low read
// - no interlock in 8-bit mode
// - width change invalidates held results
// - low result shows low eight bits
// - compare high used only in 10-bit
// - compare low checked against low result bits
// - bit 7 selects low power
// - bits 6:5 divide input clock 1/2/4/8
// - bit 4 selects long sample
// - bits 3:2 select conversion width
// - bits 1:0 select input clock source
// - first pin register covers channels 0-7
// - second pin register covers channels 8-15
// - third pin register covers channels 16-23
// - set bit removes digital port control
// - config, compare or control write aborts conversion
// - blocked transfer discarded, no complete flag
// - disabled pin floats, reads zero
// - abort keeps results, reset clears them
`timescale 1ns/1ps
`default_nettype none
module arc_regs #(
	parameter int CH = 24,
	parameter int RES_W = 10
) (
	input wire logic ref_clk_i,
	input wire logic srst_i,
	input wire logic [arc_pkg::ADDR_W-1:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic conv_done_i,
	input wire logic [RES_W-1:0] conv_result_i,
	input wire logic ctrl_write_i,
	input wire logic alt_clk_i,
	input wire logic async_clk_i,
	output logic abort_o,
	output logic restart_o,
	output logic conversion_complete_flag_o,
	output logic low_power_select_o,
	output logic long_sample_select_o,
	output logic ten_bit_mode_o,
	output logic conversion_clock_o,
	input wire logic [CH-1:0] port_out_i,
	input wire logic [CH-1:0] port_oe_i,
	input wire logic [CH-1:0] pad_in_i,
	output logic [CH-1:0] pad_out_o,
	output logic [CH-1:0] pad_oe_o,
	output logic [CH-1:0] port_in_o
);
	logic [1:0] result_high_bits_q;
	logic [7:0] result_low_byte_q;
	logic [7:0] compare_value_high_q;
	logic [7:0] compare_value_low_q;
	logic [7:0] converter_configuration_q;
	logic [7:0] analog_pin_disable_lo_q;
	logic [7:0] analog_pin_disable_mid_q;
	logic [7:0] analog_pin_disable_hi_q;
	logic compare_enable_q;
	logic compare_gt_q;
	logic conversion_complete_flag_q;
	logic block_q;
	logic valid_q;
	logic [7:0] rdata_q;
	logic [1:0] mode;
	logic is10;
	logic [RES_W-1:0] cmp_val;
	logic [RES_W-1:0] res_used;
	logic cmp_true;
	logic take;
	logic blocked;
	logic wr_cfg;
	logic mode_change;

	////////////////////////////////////////////////////////////////////////
	// configuration fields

	assign mode = converter_configuration_q[arc_pkg::CFG_MODE_HI:arc_pkg::CFG_MODE_LO];
	assign is10 = (mode == arc_pkg::MODE_10BIT);
	assign ten_bit_mode_o = is10;
	assign low_power_select_o = converter_configuration_q[arc_pkg::CFG_LPC];
	assign long_sample_select_o = converter_configuration_q[arc_pkg::CFG_LSMP];
	assign wr_cfg = wr_i && (addr_i == arc_pkg::OFF_CFG);
	// width change drops valid and interlock, result data kept
	assign mode_change = wr_cfg &&
		(wdata_i[arc_pkg::CFG_MODE_HI:arc_pkg::CFG_MODE_LO] != mode);

	////////////////////////////////////////////////////////////////////////
	// compare and transfer decision

	// high compare bits ignored in 8-bit
	assign cmp_val = is10 ? {compare_value_high_q[1:0], compare_value_low_q}
		: {2'h0, compare_value_low_q};
	assign res_used = is10 ? conv_result_i : {2'h0, conv_result_i[7:0]};
	assign cmp_true = compare_gt_q ? (res_used >= cmp_val) : (res_used < cmp_val);
	assign blocked = block_q && is10;
	assign take = conv_done_i && !blocked && (!compare_enable_q || cmp_true);
	// blocked result is discarded, another conversion requested unless compare fails
	assign restart_o = conv_done_i && blocked && (!compare_enable_q || cmp_true);

	// writes that change operating setup
	assign abort_o = wr_i && (addr_i == arc_pkg::OFF_CFG || addr_i == arc_pkg::OFF_CMP_HI
		|| addr_i == arc_pkg::OFF_CMP_LO || addr_i == arc_pkg::OFF_CTRL);

	////////////////////////////////////////////////////////////////////////
	// result registers

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			result_high_bits_q <= 2'h0;
			result_low_byte_q <= arc_pkg::RST_BYTE;
		end else if (take) begin
			result_high_bits_q <= is10 ? conv_result_i[9:8] : 2'h0;
			result_low_byte_q <= conv_result_i[7:0];
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			valid_q <= 1'b0;
		end else if (take) begin
			valid_q <= 1'b1;
		end else if (mode_change) begin
			valid_q <= 1'b0;
		end
	end

	// interlock: set on high read in 10-bit, cleared by low read
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			block_q <= 1'b0;
		end else if (rd_i && addr_i == arc_pkg::OFF_RES_LO) begin
			block_q <= 1'b0;
		end else if (rd_i && addr_i == arc_pkg::OFF_RES_HI && is10) begin
			block_q <= 1'b1;
		end else if (mode_change) begin
			block_q <= 1'b0;
		end
	end

	// completion flag: set wins over clear
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			conversion_complete_flag_q <= 1'b0;
		end else if (take) begin
			conversion_complete_flag_q <= 1'b1;
		end else if (ctrl_write_i || (rd_i && addr_i == arc_pkg::OFF_RES_LO)) begin
			conversion_complete_flag_q <= 1'b0;
		end
	end
	assign conversion_complete_flag_o = conversion_complete_flag_q;

	////////////////////////////////////////////////////////////////////////
	// writable registers

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			compare_value_high_q <= arc_pkg::RST_BYTE;
			compare_value_low_q <= arc_pkg::RST_BYTE;
		end else if (wr_i && addr_i == arc_pkg::OFF_CMP_HI) begin
			compare_value_high_q <= {6'h00, wdata_i[1:0]};
		end else if (wr_i && addr_i == arc_pkg::OFF_CMP_LO) begin
			compare_value_low_q <= wdata_i;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			converter_configuration_q <= arc_pkg::RST_BYTE;
		end else if (wr_cfg) begin
			converter_configuration_q <= wdata_i;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			compare_enable_q <= 1'b0;
			compare_gt_q <= 1'b0;
		end else if (wr_i && addr_i == arc_pkg::OFF_CTRL) begin
			compare_enable_q <= wdata_i[arc_pkg::CTRL_CMP_EN];
			compare_gt_q <= wdata_i[arc_pkg::CTRL_CMP_GT];
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			analog_pin_disable_lo_q <= arc_pkg::RST_BYTE;
			analog_pin_disable_mid_q <= arc_pkg::RST_BYTE;
			analog_pin_disable_hi_q <= arc_pkg::RST_BYTE;
		end else if (wr_i) begin
			if (addr_i == arc_pkg::OFF_PIN_LO) begin
				analog_pin_disable_lo_q <= wdata_i;
			end else if (addr_i == arc_pkg::OFF_PIN_MID) begin
				analog_pin_disable_mid_q <= wdata_i;
			end else if (addr_i == arc_pkg::OFF_PIN_HI) begin
				analog_pin_disable_hi_q <= wdata_i;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read port, data one cycle after the strobe

	// status and control words built from package bit positions
	logic [7:0] status_word;
	logic [7:0] ctrl_word;

	always_comb begin
		status_word = 8'h00;
		status_word[arc_pkg::STAT_CONVERSION_COMPLETE_FLAG] = conversion_complete_flag_q;
		status_word[arc_pkg::STAT_BLOCK] = block_q;
		status_word[arc_pkg::STAT_VALID] = valid_q;
	end

	always_comb begin
		ctrl_word = 8'h00;
		ctrl_word[arc_pkg::CTRL_CMP_EN] = compare_enable_q;
		ctrl_word[arc_pkg::CTRL_CMP_GT] = compare_gt_q;
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			rdata_q <= 8'h00;
		end else if (rd_i) begin
			if (addr_i == arc_pkg::OFF_RES_HI) begin
				// high bits read zero outside 10-bit
				rdata_q <= is10 ? {6'h00, result_high_bits_q} : 8'h00;
			end else if (addr_i == arc_pkg::OFF_RES_LO) begin
				rdata_q <= result_low_byte_q;
			end else if (addr_i == arc_pkg::OFF_CMP_HI) begin
				rdata_q <= compare_value_high_q;
			end else if (addr_i == arc_pkg::OFF_CMP_LO) begin
				rdata_q <= compare_value_low_q;
			end else if (addr_i == arc_pkg::OFF_CFG) begin
				rdata_q <= converter_configuration_q;
			end else if (addr_i == arc_pkg::OFF_PIN_LO) begin
				rdata_q <= analog_pin_disable_lo_q;
			end else if (addr_i == arc_pkg::OFF_PIN_MID) begin
				rdata_q <= analog_pin_disable_mid_q;
			end else if (addr_i == arc_pkg::OFF_PIN_HI) begin
				rdata_q <= analog_pin_disable_hi_q;
			end else if (addr_i == arc_pkg::OFF_CTRL) begin
				rdata_q <= ctrl_word;
			end else if (addr_i == arc_pkg::OFF_STAT) begin
				rdata_q <= status_word;
			end else begin
				rdata_q <= 8'h00;
			end
		end else begin
			rdata_q <= 8'h00;
		end
	end
	assign rdata_o = rdata_q;

	////////////////////////////////////////////////////////////////////////
	// conversion clock: source select then divider

	logic bus_half_q;
	logic [1:0] alt_q;
	logic [1:0] asy_q;
	logic alt_prev_q;
	logic asy_prev_q;
	logic src_tick;
	logic [2:0] div_cnt_q;
	logic [2:0] div_mask;
	logic cclk_q;

	// alternate and asynchronous clocks pass two-flop synchronizers before edge detect
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			bus_half_q <= 1'b0;
			alt_q <= 2'h0;
			asy_q <= 2'h0;
			alt_prev_q <= 1'b0;
			asy_prev_q <= 1'b0;
		end else begin
			bus_half_q <= ~bus_half_q;
			alt_q <= {alt_q[0], alt_clk_i};
			asy_q <= {asy_q[0], async_clk_i};
			alt_prev_q <= alt_q[1];
			asy_prev_q <= asy_q[1];
		end
	end

	always_comb begin
		case (converter_configuration_q[arc_pkg::CFG_CLK_HI:arc_pkg::CFG_CLK_LO])
			2'h0: src_tick = 1'b1;
			2'h1: src_tick = bus_half_q;
			2'h2: src_tick = alt_q[1] && !alt_prev_q;
			default: src_tick = asy_q[1] && !asy_prev_q;
		endcase
	end

	always_comb begin
		case (converter_configuration_q[arc_pkg::CFG_DIV_HI:arc_pkg::CFG_DIV_LO])
			2'h0: div_mask = 3'h0;
			2'h1: div_mask = 3'h1;
			2'h2: div_mask = 3'h3;
			default: div_mask = arc_pkg::DIV_MAX;
		endcase
	end

	// one conversion clock pulse per 1/2/4/8 source ticks
	// restarts on any configuration write so a new ratio starts clean
	always_ff @(posedge ref_clk_i) begin
		if (srst_i || wr_cfg) begin
			div_cnt_q <= 3'h0;
			cclk_q <= 1'b0;
		end else begin
			cclk_q <= src_tick && ((div_cnt_q & div_mask) == div_mask);
			if (src_tick) begin
				div_cnt_q <= (div_cnt_q == div_mask) ? 3'h0 : div_cnt_q + 3'h1;
			end
		end
	end
	assign conversion_clock_o = cclk_q;

	////////////////////////////////////////////////////////////////////////
	// pin handover, three groups of eight

	logic [CH-1:0] pin_dis;
	assign pin_dis = {analog_pin_disable_hi_q, analog_pin_disable_mid_q,
		analog_pin_disable_lo_q};

	for (genvar g = 0; g < CH / 8; g++) begin : g_pin
		arc_pin_group #(.W(8)) u_grp (
			.disable_i(pin_dis[g*8 +: 8]),
			.port_out_i(port_out_i[g*8 +: 8]),
			.port_oe_i(port_oe_i[g*8 +: 8]),
			.pad_in_i(pad_in_i[g*8 +: 8]),
			.pad_out_o(pad_out_o[g*8 +: 8]),
			.pad_oe_o(pad_oe_o[g*8 +: 8]),
			.port_in_o(port_in_o[g*8 +: 8])
		);
	end
endmodule : arc_regs
`default_nettype wire

// ---- tb/arc_regs_checker.sv ----
// assertions on the converter register block
// bound to arc_regs, sees only its ports
`timescale 1ns/1ps
`default_nettype none
module arc_regs_checker #(
	parameter int CH = 24
) (
	input wire logic ref_clk_i,
	input wire logic srst_i,
	input wire logic [arc_pkg::ADDR_W-1:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic conv_done_i,
	input wire logic ctrl_write_i,
	input wire logic abort_o,
	input wire logic restart_o,
	input wire logic conversion_complete_flag_o,
	input wire logic low_power_select_o,
	input wire logic ten_bit_mode_o,
	input wire logic [CH-1:0] pad_oe_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (srst_i);
	logic [7:0] wd_q;
	logic cfg_wr;
	always_ff @(posedge ref_clk_i) begin
		wd_q <= wdata_i;
	end
	assign cfg_wr = wr_i && addr_i == 4'h4;
	abort_cause_a: assert property (wr_i && addr_i inside {4'h2, 4'h3, 4'h4, 4'h8} |-> abort_o)
		else $error("abort missing on setup write");
	abort_only_a: assert property (abort_o |-> wr_i)
		else $error("abort without write");
	power_bit_a: assert property (cfg_wr |=> low_power_select_o == wd_q[7])
		else $error("low power select wrong");
	width_sel_a: assert property (cfg_wr |=> ten_bit_mode_o == (wd_q[3:2] == 2'h2))
		else $error("width select wrong");
	pin_float_a: assert property (wr_i && addr_i == 4'h5 |=> (pad_oe_o[7:0] & wd_q) == 8'h00)
		else $error("disabled pin driven");
	high_zero_a: assert property (rd_i && addr_i == 4'h0 && !ten_bit_mode_o |=> rdata_o == 8'h00)
		else $error("high result not zero");
	restart_cause_a: assert property (restart_o |-> conv_done_i && ten_bit_mode_o)
		else $error("restart without blocked result");
	flag_hold_a: assert property (restart_o && !rd_i && !ctrl_write_i |=>
		$stable(conversion_complete_flag_o))
		else $error("flag moved on blocked result");
	cover property (restart_o);
	cover property (abort_o);
	cover property ($rose(conversion_complete_flag_o));
endmodule : arc_regs_checker
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench for arc_regs with a reference model
// assumes 20 MHz bus clock and synchronous reset
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic ref_clk_i = 1'b0, srst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
	logic conv_done_i = 1'b0, ctrl_write_i = 1'b0, alt_clk_i = 1'b0, async_clk_i = 1'b0;
	logic [3:0] addr_i = 4'h0;
	logic [7:0] wdata_i = 8'h00, rdata_o;
	logic [9:0] conv_result_i = 10'h000;
	logic [23:0] port_out_i = 24'h0, port_oe_i = 24'h0, pad_in_i = 24'h0, pad_out_o, pad_oe_o;
	logic [23:0] port_in_o, dis;
	logic abort_o, restart_o, conversion_complete_flag_o, low_power_select_o;
	logic long_sample_select_o, ten_bit_mode_o, conversion_clock_o;
	logic [31:0] st = 32'hF;
	logic [7:0] mem [16];
	logic [9:0] res, r;
	bit m10, val, blk, flg, cen, cgt;
	int errors, compares, tick, n, p;
	arc_regs dut_u (
		.ref_clk_i(ref_clk_i),
		.srst_i(srst_i),
		.addr_i(addr_i),
		.wdata_i(wdata_i),
		.wr_i(wr_i),
		.rd_i(rd_i),
		.rdata_o(rdata_o),
		.conv_done_i(conv_done_i),
		.conv_result_i(conv_result_i),
		.ctrl_write_i(ctrl_write_i),
		.alt_clk_i(alt_clk_i),
		.async_clk_i(async_clk_i),
		.abort_o(abort_o),
		.restart_o(restart_o),
		.conversion_complete_flag_o(conversion_complete_flag_o),
		.low_power_select_o(low_power_select_o),
		.long_sample_select_o(long_sample_select_o),
		.ten_bit_mode_o(ten_bit_mode_o),
		.conversion_clock_o(conversion_clock_o),
		.port_out_i(port_out_i),
		.port_oe_i(port_oe_i),
		.pad_in_i(pad_in_i),
		.pad_out_o(pad_out_o),
		.pad_oe_o(pad_oe_o),
		.port_in_o(port_in_o)
	);
	initial forever #25 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) begin
		tick++;
		if (tick % 3 == 0) alt_clk_i <= ~alt_clk_i;
		if (tick % 5 == 0) async_clk_i <= ~async_clk_i;
	end
	function automatic logic [31:0] xs();
		st ^= st << 13;
		st ^= st >> 17;
		st ^= st << 5;
		return st;
	endfunction : xs
	task automatic chk(input logic [23:0] s, input logic [23:0] e);
		compares++;
		if (s !== e) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, s, e);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(negedge ref_clk_i);
		chk(abort_o, a inside {4'h2, 4'h3, 4'h4, 4'h8});
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
		if (a == 4'h4 && d[3:2] != mem[4][3:2]) {val, blk} = 2'b00;
		if (a == 4'h4) m10 = d[3:2] == 2'h2;
		if (a == 4'h8) {cgt, cen} = d[1:0];
		if (a > 4'h1 && a < 4'h8) mem[a] = (a == 4'h2) ? (d & 8'h03) : d;
	endtask : wr
	task automatic rd(input logic [3:0] a);
		logic [7:0] e;
		case (a)
			4'h0: e = m10 ? {6'h00, res[9:8]} : 8'h00;
			4'h1: e = res[7:0];
			4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7: e = mem[a];
			4'h8: e = {6'h00, cgt, cen};
			4'h9: e = {5'h00, val, blk, flg};
			default: e = 8'h00;
		endcase
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		@(negedge ref_clk_i);
		chk(rdata_o, e);
		if (a == 4'h0 && m10) blk = 1'b1;
		if (a == 4'h1) {blk, flg} = 2'b00;
		chk(conversion_complete_flag_o, flg);
	endtask : rd
	task automatic cv(input logic [9:0] v);
		logic [9:0] c, x;
		bit ok;
		c = m10 ? {mem[2][1:0], mem[3]} : {2'h0, mem[3]};
		x = m10 ? v : {2'h0, v[7:0]};
		ok = !cen || (cgt ? x >= c : x < c);
		@(posedge ref_clk_i);
		conv_done_i <= 1'b1;
		conv_result_i <= v;
		@(negedge ref_clk_i);
		chk(restart_o, ok && blk);
		@(posedge ref_clk_i);
		conv_done_i <= 1'b0;
		if (ok && !blk) {res, val, flg} = {x, 2'b11};
	endtask : cv
	task automatic report_and_stop();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : report_and_stop
	initial begin
		foreach (mem[i]) mem[i] = 8'h00;
		res = 10'h000;
		repeat (6) @(posedge ref_clk_i);
		srst_i <= 1'b0;
		for (int a = 0; a < 16; a++) rd(4'(a));
		$display("test reset done");
		for (int i = 0; i < 24; i++) begin
			wr(4'(2 + xs() % 14), 8'(xs()));
			rd(addr_i);
			chk({low_power_select_o, long_sample_select_o, ten_bit_mode_o},
				{mem[4][7], mem[4][4], mem[4][3:2] == 2'h2});
		end
		$display("test registers done");
		for (int i = 0; i < 8; i++) begin
			for (int g = 0; g < 3; g++) wr(4'(5 + g), 8'(xs()));
			port_out_i <= 24'(xs());
			port_oe_i <= 24'(xs());
			pad_in_i <= 24'(xs());
			@(negedge ref_clk_i);
			dis = {mem[7], mem[6], mem[5]};
			chk(pad_oe_o, port_oe_i & ~dis);
			chk(port_in_o, pad_in_i & ~dis);
			chk(pad_out_o & ~dis, port_out_i & ~dis);
		end
		$display("test pins done");
		for (int i = 0; i < 16; i++) begin
			r = 10'(xs());
			wr(4'h4, i[0] ? 8'h08 : 8'h00);
			wr(4'h8, {6'h00, i[1], i < 12});
			wr(4'h3, i[2] ? r[7:0] : 8'(xs()));
			wr(4'h2, i[3] ? {6'h00, r[9:8]} : 8'(xs()));
			cv(r);
			rd(4'h9);
			rd(4'h0);
			cv(10'(xs()));
			rd(4'h9);
			rd(4'h1);
		end
		$display("test compare and interlock done");
		cv(10'h2A5);
		@(posedge ref_clk_i);
		ctrl_write_i <= 1'b1;
		@(posedge ref_clk_i);
		ctrl_write_i <= 1'b0;
		flg = 1'b0;
		rd(4'h9);
		wr(4'h3, 8'h11);
		rd(4'h1);
		@(posedge ref_clk_i);
		srst_i <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		srst_i <= 1'b0;
		foreach (mem[i]) mem[i] = 8'h00;
		{res, m10, val, blk, flg, cen, cgt} = 16'h0000;
		rd(4'h1);
		rd(4'h9);
		$display("test abort and reset done");
		for (int k = 0; k < 16; k++) begin
			wr(4'h4, {1'b0, 2'(k >> 2), 3'h0, 2'(k)});
			n = 0;
			repeat (240) begin
				@(negedge ref_clk_i);
				n += conversion_clock_o;
			end
			p = (k % 4 == 0 ? 1 : k % 4 == 1 ? 2 : k % 4 == 2 ? 6 : 10) << (k / 4);
			chk(n >= 240 / p - 1 && n <= 240 / p + 1, 1'b1);
		end
		$display("test clock divide done");
		report_and_stop();
	end
endmodule : tb
bind arc_regs arc_regs_checker #(.CH(CH)) chk_u (
	.ref_clk_i(ref_clk_i),
	.srst_i(srst_i),
	.addr_i(addr_i),
	.wdata_i(wdata_i),
	.wr_i(wr_i),
	.rd_i(rd_i),
	.rdata_o(rdata_o),
	.conv_done_i(conv_done_i),
	.ctrl_write_i(ctrl_write_i),
	.abort_o(abort_o),
	.restart_o(restart_o),
	.conversion_complete_flag_o(conversion_complete_flag_o),
	.low_power_select_o(low_power_select_o),
	.ten_bit_mode_o(ten_bit_mode_o),
	.pad_oe_o(pad_oe_o)
);
`default_nettype wire
